// >>> src/mcu_pkg.sv
// constants, register map and carrier types for the machine check unit
// assumes a 32-bit classic wishbone register bus and big-endian bit numbers
package mcu_pkg;

	// register byte offsets on the wishbone bus
	localparam logic [7:0] MCU_OFF_CFG    = 8'h00; // error enables
	localparam logic [7:0] MCU_OFF_MSTATE = 8'h04; // machine state
	localparam logic [7:0] MCU_OFF_SSTAT  = 8'h08; // saved status
	localparam logic [7:0] MCU_OFF_SRADDR = 8'h0C; // save-restore address
	localparam logic [7:0] MCU_OFF_STATUS = 8'h10; // block state, read only

	// config fields, lsb index (documented bit n sits at 31-n)
	localparam int MCU_CFG_EXT_EN   = 31; // config bit 0
	localparam int MCU_CFG_PAR_GEN  = 30; // config bit 1
	localparam int MCU_CFG_ADDR_CHK = 29; // config bit 2
	localparam int MCU_CFG_DATA_CHK = 28; // config bit 3
	localparam int MCU_CFG_NOT_COLD = 16; // config bit 15

	// machine state fields, lsb index
	localparam int MCU_MS_INT_ENDIAN = 16; // bit 15
	localparam int MCU_MS_MC_ENABLE  = 12; // bit 19
	localparam int MCU_MS_VEC_PREFIX = 6;  // bit 25
	localparam int MCU_MS_LITTLE_END = 0;  // bit 31

	// saved status cause fields, lsb index
	localparam int MCU_SS_L2_PAR   = 20; // bit 11
	localparam int MCU_SS_EXT      = 19; // bit 12
	localparam int MCU_SS_TEA      = 18; // bit 13
	localparam int MCU_SS_DATA_PAR = 17; // bit 14
	localparam int MCU_SS_ADDR_PAR = 16; // bit 15

	// values after reset
	localparam logic [31:0] MCU_RST_CFG    = 32'h0000_0000;
	localparam logic [31:0] MCU_RST_MSTATE = 32'h0000_0000;
	localparam logic [31:0] MCU_RST_WORD   = 32'h0000_0000;

	// vector construction
	localparam logic [31:0] MCU_VEC_OFFSET = 32'h0000_0200;
	localparam logic [31:0] MCU_BASE_LOW   = 32'h0000_0000;
	localparam logic [31:0] MCU_BASE_HIGH  = 32'hFFF0_0000;

	// internal error sources, one-cycle pulses from core logic
	typedef struct packed {
		logic addr_par; // bus address parity error
		logic data_par; // bus data parity error
		logic l1_par;   // l1 cache parity error
		logic l2_par;   // l2 cache parity error
	} mcu_err_t;

	// exception request towards the fetch unit
	typedef struct packed {
		logic        take;  // one-cycle exception strobe
		logic [31:0] vaddr; // handler fetch address
	} mcu_vec_t;

	// core state of the unit
	typedef enum logic [0:0] {
		MCU_RUN  = 1'b0,
		MCU_STOP = 1'b1
	} mcu_state_t;

endpackage

// >>> src/mcu_unit.sv
// machine check and checkstop unit with its wishbone register slave
// assumes error sources on clk_i except the two bus pins, which are
// synchronised here; the core honours halt_o and the vector strobe
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps

module mcu_unit (
	// clock and resets
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 soft_rst_i,
	// wishbone slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [7:0]           adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	// error sources
	input  wire mcu_pkg::mcu_err_t    err_i,
	input  wire logic                 bus_transfer_error_ack_i,
	input  wire logic                 ext_machine_check_in_i,
	// core side
	input  wire logic [31:0]          current_ea_i,
	output mcu_pkg::mcu_vec_t         vec_o,
	output logic                      halt_o,
	output logic                      freeze_o,
	output logic                      bus_parity_gen_ctrl_o,
	output logic                      little_endian_mode_o
);
	import mcu_pkg::*;

	// byte-lane merge for register writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// agreed level: updates only when second and third stage match
	function automatic logic agree(input logic cur, input logic s2,
		input logic s3);
		return (s2 == s3) ? s2 : cur;
	endfunction

	// registers
	logic [31:0] cfg_q,    cfg_d;    // error enables
	logic [31:0] ms_q,     ms_d;     // machine state
	logic [31:0] ss_q,     ss_d;     // saved status
	logic [31:0] sra_q,    sra_d;    // save-restore address
	mcu_state_t  st_q,     st_d;     // run or checkstop
	logic        ack_q;              // bus answer
	logic [31:0] rdat_q;             // read data
	mcu_vec_t    vec_q;              // vector strobe

	// pin synchronisers, three stages each
	logic [2:0]  tea_s_q;            // transfer error pin
	logic [2:0]  ext_s_q;            // external check pin
	logic        tea_lv_q;           // agreed transfer error level
	logic        ext_lv_q;           // agreed external check level

	// a write lands on the edge that first sees the request; ack_q then
	// masks the still-held strobe so the same write cannot land twice
	// decoded wires
	wire         bus_req   = cyc_i & stb_i;
	wire         wr_stb    = bus_req & we_i & ~ack_q;
	wire         hit_cfg   = adr_i == MCU_OFF_CFG;
	wire         hit_ms    = adr_i == MCU_OFF_MSTATE;
	wire         hit_ss    = adr_i == MCU_OFF_SSTAT;
	wire         hit_sra   = adr_i == MCU_OFF_SRADDR;
	wire         hit_st    = adr_i == MCU_OFF_STATUS;
	wire         stopped   = st_q == MCU_STOP;
	wire         tea_lv_d  = agree(tea_lv_q, tea_s_q[1], tea_s_q[2]);
	wire         ext_lv_d  = agree(ext_lv_q, ext_s_q[1], ext_s_q[2]);

	// qualified sources
	wire         src_tea   = tea_lv_d & ~tea_lv_q;
	wire         src_ext   = ext_lv_d & ~ext_lv_q
		& cfg_q[MCU_CFG_EXT_EN];
	wire         src_addr  = err_i.addr_par
		& cfg_q[MCU_CFG_ADDR_CHK];
	wire         src_data  = err_i.data_par
		& cfg_q[MCU_CFG_DATA_CHK];
	wire         src_l1    = err_i.l1_par;
	wire         src_l2    = err_i.l2_par;

	// any source raises the condition, nothing once stopped
	wire         mc_cond   = ~stopped & (src_tea | src_ext | src_addr
		| src_data | src_l1 | src_l2);
	wire         mc_en     = ms_q[MCU_MS_MC_ENABLE];
	wire         take_exc  = mc_cond & mc_en;
	wire         go_stop   = mc_cond & ~mc_en;

	// cause word and new machine state on entry
	wire [31:0]  cause;
	wire [31:0]  ms_entry;
	wire [31:0]  vec_base;
	assign cause = {11'h000, src_l2, src_ext, src_tea, src_data,
		src_addr, ms_q[15:0]};
	assign ms_entry = (32'h1 << MCU_MS_INT_ENDIAN) & ms_q
		| (32'h1 << MCU_MS_VEC_PREFIX) & ms_q
		| {31'h0, ms_q[MCU_MS_INT_ENDIAN]};
	assign vec_base = ms_q[MCU_MS_VEC_PREFIX] ? MCU_BASE_HIGH
		: MCU_BASE_LOW;

	// read mux
	wire [31:0]  rd_mux = hit_cfg ? cfg_q
		: hit_ms  ? ms_q
		: hit_ss  ? ss_q
		: hit_sra ? sra_q
		: hit_st  ? {31'h0, stopped}
		: 32'h0000_0000;

	// next state of config: frozen once stopped
	always_comb begin
		cfg_d = cfg_q;
		if (wr_stb & hit_cfg & ~stopped) begin
			cfg_d = lane_merge(cfg_q, dat_i, sel_i);
		end
	end

	// next machine state: entry beats a software write
	always_comb begin
		ms_d = ms_q;
		if (stopped) begin
			ms_d = ms_q;
		end else if (take_exc) begin
			ms_d = ms_entry;
		end else if (wr_stb & hit_ms) begin
			ms_d = lane_merge(ms_q, dat_i, sel_i);
		end
	end

	// next saved status: hardware set wins over write
	always_comb begin
		ss_d = ss_q;
		if (stopped) begin
			ss_d = ss_q;
		end else if (take_exc) begin
			ss_d = cause;
		end else if (wr_stb & hit_ss) begin
			ss_d = lane_merge(ss_q, dat_i, sel_i);
		end
	end

	// next save-restore address
	always_comb begin
		sra_d = sra_q;
		if (stopped) begin
			sra_d = sra_q;
		end else if (take_exc) begin
			sra_d = current_ea_i;
		end else if (wr_stb & hit_sra) begin
			sra_d = lane_merge(sra_q, dat_i, sel_i);
		end
	end

	// checkstop entry, left only by a reset
	always_comb begin
		case (st_q)
			MCU_RUN: begin
				st_d = go_stop ? MCU_STOP : MCU_RUN;
			end
			MCU_STOP: begin
				st_d = MCU_STOP;
			end
			default: begin
				st_d = MCU_RUN;
			end
		endcase
	end

	// pin synchronisers
	// stage 0 feeds only stage 1; the agreed level reads stages 1 and 2
	// hard reset only, so a soft reset cannot fake a pin edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tea_s_q  <= 3'h0;
			ext_s_q  <= 3'h0;
			tea_lv_q <= 1'b0;
			ext_lv_q <= 1'b0;
		end else begin
			tea_s_q  <= {tea_s_q[1:0], bus_transfer_error_ack_i};
			ext_s_q  <= {ext_s_q[1:0], ext_machine_check_in_i};
			tea_lv_q <= tea_lv_d;
			ext_lv_q <= ext_lv_d;
		end
	end

	// config keeps its flag across a soft reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= MCU_RST_CFG;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// architectural state, restarted by either reset
	always_ff @(posedge clk_i) begin
		if (rst_i | soft_rst_i) begin
			ms_q  <= MCU_RST_MSTATE;
			ss_q  <= MCU_RST_WORD;
			sra_q <= MCU_RST_WORD;
			st_q  <= MCU_RUN;
		end else begin
			ms_q  <= ms_d;
			ss_q  <= ss_d;
			sra_q <= sra_d;
			st_q  <= st_d;
		end
	end

	// vector strobe
	always_ff @(posedge clk_i) begin
		if (rst_i | soft_rst_i) begin
			vec_q <= '0;
		end else begin
			vec_q.take  <= take_exc;
			vec_q.vaddr <= vec_base | MCU_VEC_OFFSET;
		end
	end

	// wishbone answer, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= MCU_RST_WORD;
		end else begin
			ack_q  <= bus_req & ~ack_q;
			rdat_q <= rd_mux;
		end
	end

	// outputs
	assign dat_o                 = rdat_q;
	assign ack_o                 = ack_q;
	assign vec_o                 = vec_q;
	assign halt_o                = stopped;
	assign freeze_o              = stopped;
	assign bus_parity_gen_ctrl_o = cfg_q[MCU_CFG_PAR_GEN];
	assign little_endian_mode_o  = ms_q[MCU_MS_LITTLE_END];

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i | soft_rst_i);

	chk_cause_flags: assert property (
		take_exc |=> ss_q[20:16] == $past(cause[20:16]))
		else $error("cause flags not captured");
	chk_stop_entry: assert property (
		go_stop |=> stopped ##1 stopped)
		else $error("checkstop not entered");
	chk_stop_hold: assert property (
		stopped |=> stopped && halt_o)
		else $error("checkstop left without reset");
	chk_freeze_regs: assert property (
		stopped ##1 stopped |-> $stable(ms_q) && $stable(ss_q)
		&& $stable(cfg_q))
		else $error("latches not frozen");
	chk_vector_addr: assert property (
		take_exc |=> vec_o.take && vec_o.vaddr[19:0] == 20'h0_0200
		&& vec_o.vaddr[31:20] == ($past(ms_q[6]) ? 12'hFFF : 12'h000))
		else $error("bad vector address");
	chk_state_entry: assert property (
		take_exc |=> !ms_q[12] && ms_q[0] == $past(ms_q[16])
		&& ms_q[16] == $past(ms_q[16]))
		else $error("bad machine state on entry");
	chk_ext_mask: assert property (
		!cfg_q[31] && !(src_tea | err_i.addr_par | err_i.data_par
		| src_l1 | src_l2) |-> !mc_cond)
		else $error("masked pin raised a check");
	chk_addr_save: assert property (
		take_exc |=> sra_q == $past(current_ea_i))
		else $error("save address not loaded");
	chk_bus_ack: assert property (
		bus_req && !ack_q |=> ack_q ##1 !ack_q)
		else $error("bus answer timing wrong");
	chk_low_clear: assert property (
		take_exc |=> ss_q[31:21] == 11'h000
		&& ss_q[15:0] == $past(ms_q[15:0]))
		else $error("saved status low bits wrong");

	// the strobe cannot repeat: entry clears the enable bit
	chk_take_single: assert property (
		vec_o.take |=> !vec_o.take)
		else $error("exception strobe repeated");
	// only endian and prefix bits and the endian copy survive entry
	chk_state_clear: assert property (
		take_exc |=> (ms_q & 32'hFFFE_FFBE) == 32'h0000_0000)
		else $error("machine state not cleared on entry");
	// l2 parity always lands in its own cause bit
	chk_l2_cause: assert property (
		take_exc && err_i.l2_par |=> ss_q[MCU_SS_L2_PAR])
		else $error("l2 cause bit missing");
	// enabled address parity lands in its own cause bit
	chk_addr_cause: assert property (
		take_exc && err_i.addr_par && cfg_q[MCU_CFG_ADDR_CHK]
		|=> ss_q[MCU_SS_ADDR_PAR])
		else $error("address parity cause bit missing");
	// a masked address error with the enable clear must not stop
	chk_addr_mask: assert property (
		!stopped && !cfg_q[MCU_CFG_ADDR_CHK]
		&& !ms_q[MCU_MS_MC_ENABLE]
		&& !(src_tea | src_ext | src_data | src_l1 | src_l2)
		|=> !stopped)
		else $error("masked address parity stopped the core");
	// hard reset clears the config word, flag included
	chk_hard_clear: assert property (
		disable iff (1'b0) rst_i |=> cfg_q == MCU_RST_CFG)
		else $error("config not cleared by hard reset");
	// soft reset keeps the config word while the bus is idle
	chk_soft_keep: assert property (
		disable iff (rst_i) soft_rst_i && !bus_req |=> $stable(cfg_q))
		else $error("config changed by soft reset");
	// soft reset leaves checkstop and drops the strobe
	chk_soft_unstop: assert property (
		disable iff (rst_i) soft_rst_i |=> !stopped && !vec_o.take)
		else $error("soft reset did not restart");

endmodule

// >>> verif/mcu_far_end.sv
// far side model: memory controller and board error sources
// assumes the bench raises req_i for exactly one cycle per event
`timescale 1ns/10ps

module mcu_far_end
	import mcu_pkg::*;
(
	// clock and bench request
	input  wire logic       clk_i,
	input  wire logic [5:0] req_i,
	// error lines
	output mcu_err_t        err_o,
	output logic            tea_o,
	output logic            ext_o
);
	logic [2:0] hold_q; // pin hold count

	initial begin
		err_o = '0;
		tea_o = 1'b0;
		ext_o = 1'b0;
		hold_q = 3'h0;
	end

	// internal sources pulse, pins stay high a few cycles
	always @(posedge clk_i) begin
		err_o <= {req_i[0], req_i[1], req_i[2], req_i[3]};
		hold_q <= (|req_i[5:4]) ? 3'h4 : hold_q - (hold_q != 0);
		tea_o <= req_i[4] | (tea_o & (hold_q > 1));
		ext_o <= req_i[5] | (ext_o & (hold_q > 1));
	end
endmodule

// >>> verif/mcu_unit_tb.sv
// bench for the machine check unit, with a behavioural model
// assumes the far end model drives all error sources
`timescale 1ns/10ps

module mcu_unit_tb;
	import mcu_pkg::*;
	logic        clk_i, rst_i, srst, cyc, we, ack, halt, frz, pg, le;
	logic [7:0]  adr;
	logic [31:0] dat, rd, ea, va, cfg_m, s, rv;
	logic [5:0]  req;
	mcu_err_t    err;
	mcu_vec_t    vec;
	logic        bus_transfer_error_ack, ext;
	int          fail_count, num_checks, tk;
	int          cb[6] = '{16, 17, 0, 20, 18, 19}; // cause index

	mcu_unit i_mcu_unit (.clk_i(clk_i), .rst_i(rst_i),
		.soft_rst_i(srst), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
		.adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rd),
		.ack_o(ack), .err_i(err), .bus_transfer_error_ack_i(bus_transfer_error_ack),
		.ext_machine_check_in_i(ext), .current_ea_i(ea),
		.vec_o(vec), .halt_o(halt), .freeze_o(frz),
		.bus_parity_gen_ctrl_o(pg), .little_endian_mode_o(le));
	mcu_far_end i_mcu_far_end (.clk_i(clk_i), .req_i(req),
		.err_o(err), .tea_o(bus_transfer_error_ack), .ext_o(ext));

	// clock and time-zero values
	initial begin
		clk_i = 1'b0;
		{srst, cyc, we} = 3'h0;
		adr = 8'h00;
		dat = 32'h0000_0000;
		ea = 32'h0000_0000;
		req = 6'h00;
		rst_i = 1'b1;
		s = 32'h0000_bdd7;
		forever #2.5 clk_i = ~clk_i;
	end
	// count exception strobes
	always @(posedge clk_i) if (vec.take === 1'b1) begin
		tk <= tk + 1;
		va <= vec.vaddr;
	end
	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end

	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// classic wishbone single cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		r = rd;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rs(input logic h);
		rst_i <= h;
		srst <= !h;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		srst <= 1'b0;
		@(posedge clk_i);
		if (h) cfg_m = 32'h0;
	endtask
	// one event: m is {ext,tea,l2,l1,data,addr}
	task automatic ev(input logic [5:0] m, input logic me);
		logic [31:0] ms, ex, r;
		int k, n0;
		logic hit;
		ms = (xs() & 32'h0001_0041) | (32'(me) << 12);
		wb(1'b1, MCU_OFF_MSTATE, ms, r);
		ea <= xs();
		ex = 0;
		hit = 0;
		for (k = 0; k < 6; k++)
			if (m[k] && (k == 0 ? cfg_m[29] : k == 1 ? cfg_m[28] :
				k == 5 ? cfg_m[31] : 1'b1)) begin
				hit = 1;
				if (k != 2) ex[cb[k]] = 1'b1;
			end
		n0 = tk;
		@(posedge clk_i) req <= m;
		@(posedge clk_i) req <= 6'h0;
		k = 0;
		while (tk == n0 && halt !== 1'b1 && k < 12) begin
			@(posedge clk_i);
			k++;
		end
		if (!me) cmp(halt, hit);
		else begin
			cmp(tk - n0, hit);
			if (hit) begin
				cmp(va, (ms[6] ? MCU_BASE_HIGH : MCU_BASE_LOW) | 32'h200);
				wb(1'b0, MCU_OFF_SSTAT, 0, r);
				cmp(r, ex | (ms & 32'hffff));
				wb(1'b0, MCU_OFF_SRADDR, 0, r);
				cmp(r, ea);
				wb(1'b0, MCU_OFF_MSTATE, 0, r);
				cmp(r, (ms & 32'h0001_0040) | ms[16]);
				cmp(le, ms[16]);
			end
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// main sequence
	initial begin
		int i;
		#1;
		rs(1'b1);
		for (i = 0; i < 6; i++) begin
			wb(1'b0, 8'(i * 4), 0, rv);
			cmp(rv, 0);
		end
		cfg_m = 32'hF001_0000;
		wb(1'b1, MCU_OFF_CFG, cfg_m, rv);
		cmp(pg, 1);
		for (i = 0; i < 6; i++) ev(6'(1 << i), 1'b1);
		ev(6'b001011, 1'b1);
		cfg_m = 32'h0001_0000;
		wb(1'b1, MCU_OFF_CFG, cfg_m, rv);
		cmp(pg, 0);
		ev(6'b100011, 1'b1);
		ev(6'b100011, 1'b0);
		cfg_m = 32'hF001_0000;
		wb(1'b1, MCU_OFF_CFG, cfg_m, rv);
		ev(6'b001000, 1'b0);
		cmp(frz, 1);
		wb(1'b1, MCU_OFF_CFG, 0, rv);
		wb(1'b0, MCU_OFF_CFG, 0, rv);
		cmp(rv, cfg_m);
		wb(1'b0, MCU_OFF_STATUS, 0, rv);
		cmp(rv, 1);
		rs(1'b0);
		cmp(halt, 0);
		wb(1'b0, MCU_OFF_CFG, 0, rv);
		cmp(rv, cfg_m);
		rs(1'b1);
		wb(1'b0, MCU_OFF_CFG, 0, rv);
		cmp(rv, 0);
		tally_and_finish();
	end
endmodule
